// >>> dsciod_regs.svh
`ifndef DSCIOD_REGS_SVH
`define DSCIOD_REGS_SVH

// word and field layout
`define DSCIOD_WORD_W       24
`define DSCIOD_INSTR_W      48
`define DSCIOD_OPC_LO       40
`define DSCIOD_ZERO_HI_W    8
`define DSCIOD_ACC_BIT      39
`define DSCIOD_BYTE_BIT     38
`define DSCIOD_BASE_LO      34
`define DSCIOD_DEST_LO      30
`define DSCIOD_SRC_LO       24
`define DSCIOD_BITSEL_LO    24
`define DSCIOD_ULIT_LO      28
`define DSCIOD_WB_LO        24
`define DSCIOD_XPF_LO       26
`define DSCIOD_YPF_LO       30
`define DSCIOD_XD_LO        36
`define DSCIOD_YD_LO        34
`define DSCIOD_MUL_LO       36
`define DSCIOD_ADDR_LO_LO   24
`define DSCIOD_ADDR_HI_LO   0
`define DSCIOD_DEFAULT_REG  4'h0
`define DSCIOD_WB_DIRECT    2'h1
`define DSCIOD_WB_POSTINC   2'h2
`define DSCIOD_WB_BAD       2'h3
`define DSCIOD_MUL_BAD_MIN  3'h6
`define DSCIOD_PF_SPECIAL   3'h7

// opcode values of the timing classes
`define DSCIOD_OP_NOP       8'h00
`define DSCIOD_OP_COMPUTED  8'h01
`define DSCIOD_OP_IND_JUMP  8'h02
`define DSCIOD_OP_IND_CALL  8'h03
`define DSCIOD_OP_JUMP_DBL  8'h04
`define DSCIOD_OP_CALL_DBL  8'h05
`define DSCIOD_OP_RETURN    8'h06
`define DSCIOD_OP_INT_RET   8'h07
`define DSCIOD_OP_MOV_DBL   8'h08
`define DSCIOD_OP_COND      8'h31
`define DSCIOD_OP_BRANCH    8'h37
`define DSCIOD_OP_SKIP      8'ha4
`define DSCIOD_OP_TBL_RD    8'hba
`define DSCIOD_OP_TBL_WR    8'hbb
`define DSCIOD_OP_MPY       8'hc0
`define DSCIOD_OP_SQR       8'hf0

// instruction cycle counts
`define DSCIOD_CYC_TAKEN    2'd2
`define DSCIOD_CYC_BRANCH   2'd2
`define DSCIOD_CYC_IND      2'd2
`define DSCIOD_CYC_TABLE    2'd2
`define DSCIOD_CYC_RETURN   2'd3
`define DSCIOD_CYC_DOUBLE   2'd2

`endif

// >>> dsciod_pkg.sv
`include "dsciod_regs.svh"

package dsciod_pkg;

    typedef enum logic [3:0] {
        CLS_PLAIN, CLS_NOP, CLS_COND, CLS_BRANCH, CLS_IND,
        CLS_TABLE, CLS_RETURN, CLS_SKIP, CLS_DOUBLE
    } dsciod_class_t;

    typedef enum logic [2:0] {
        S_FETCH, S_SECOND, S_EXEC, S_FILL, S_SKIP, S_SKIP2
    } dsciod_state_t;

    typedef struct packed {
        logic       none;
        logic       indexed;
        logic [3:0] areg;
        logic [3:0] step;
    } dsciod_pf_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic negative;
        logic overflow_flag;
        logic zero;
        logic acc_a_overflow;
        logic acc_b_overflow;
        logic acc_a_saturate;
        logic acc_b_saturate;
    } dsciod_flags_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic        byte_mode;
        logic [3:0]  base_work_reg;
        logic [3:0]  source_work_reg;
        logic [3:0]  dest_work_reg;
        logic [3:0]  default_work_reg;
        logic [3:0]  bit_select_field;
        logic [9:0]  unsigned_literal_ten;
        logic [15:0] signed_literal_ten;
        logic [22:0] program_addr_literal;
        logic        acc_sel;
        logic [1:0]  acc_writeback_dest;
        logic [3:0]  mul_m;
        logic [3:0]  mul_n;
        dsciod_pf_t  x_prefetch_addr;
        dsciod_pf_t  y_prefetch_addr;
        logic [3:0]  x_prefetch_dest;
        logic [3:0]  y_prefetch_dest;
    } dsciod_fields_t;

    typedef struct packed {
        logic lit_range;
        logic addr_odd;
        logic mul_pair;
        logic wb_code;
        logic second_word;
    } dsciod_err_t;

endpackage

// >>> dsciod_pfdec.sv
`timescale 1ns/1ps
`default_nettype none

module dsciod_pfdec
    import dsciod_pkg::*;
#(
    parameter logic [3:0] BASE_REG = 4'h8
) (
    input  wire logic [3:0] i_code,
    input  wire logic [1:0] i_dcode,
    output dsciod_pf_t      o_pf,
    output logic      [3:0] o_dest
);

    always_comb begin
        o_pf.none    = 1'b0;
        o_pf.indexed = 1'b0;
        o_pf.areg    = BASE_REG + {3'h0, i_code[3]};
        case (i_code[2:0])
            3'h0: o_pf.step = 4'h0;
            3'h1: o_pf.step = 4'h2;
            3'h2: o_pf.step = 4'h4;
            3'h3: o_pf.step = 4'h6;
            3'h4: o_pf.step = 4'ha;
            3'h5: o_pf.step = 4'hc;
            3'h6: o_pf.step = 4'he;
            default: begin
                o_pf.step    = 4'h0;
                o_pf.none    = ~i_code[3];
                o_pf.indexed = i_code[3];
            end
        endcase
    end

    // destination confined to the four multiplier registers
    assign o_dest = {2'h1, i_dcode};

endmodule

`default_nettype wire

// >>> dsciod_flags.sv
`timescale 1ns/1ps
`default_nettype none

module dsciod_flags
    import dsciod_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire dsciod_flags_t i_we,
    input  wire dsciod_flags_t i_val,
    output dsciod_flags_t      o_flags
);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_flags <= '0;
        end else begin
            o_flags <= (o_flags & ~i_we) | (i_val & i_we);
        end
    end

endmodule

`default_nettype wire

// >>> dsciod_issue.sv
// Summary of operation
// - double-word instructions join two fetched words into one 48-bit instruction
// - second word has top 8 bits zero; alone it issues as a no-op
// - plain single-word instructions take one cycle without taken test or pc change
// - taken condition or pc change costs two cycles, extra one a no-op
// - branch, computed branch, indirect call/jump, table access, returns take 2-3 cycles
// - taken skip costs two cycles, three when skipped instruction is double-word
// - every double-word instruction executes in exactly two cycles
// - write-back destination is register 13 or its location with post-increment two
// - bit-select operand is a 4-bit field choosing bits 0 to 15
// - unsigned ten-bit literal limited to 255 in byte mode, 1023 in word
// - 23-bit program address literal always has its least bit zero
// - signed ten-bit literal is two's complement and sign-extended
// - square multiply uses identical pairs of registers 4 to 7
// - multiply uses one of six distinct pairs from registers 4 to 7
// - x prefetch uses register 8 or 9, modified, indexed by 12, or none
// - y prefetch uses register 10 or 11, modified, indexed by 12, or none
// - prefetch destinations are registers 4 to 7
// - file-register instructions use register 0 as implied destination
// - base, source and destination fields each pick one of 16 registers
// - accumulator operand picks exactly one of accumulators A and B
// - status flags kept for core and both accumulators
// - each single word is 24 bits with an 8-bit opcode in front
`timescale 1ns/1ps
`default_nettype none
`include "dsciod_regs.svh"

module dsciod_issue
    import dsciod_pkg::*;
(
    input  wire logic          I_CLK,
    input  wire logic          I_RST_N,
    input  wire logic          I_FETCH_VALID,
    input  wire logic [23:0]   I_FETCH_WORD,
    output logic               O_FETCH_READY,
    input  wire logic          I_COND_TRUE,
    input  wire logic          I_PC_WRITE,
    input  wire logic          I_SKIP_TAKEN,
    input  wire dsciod_flags_t I_FLAG_WE,
    input  wire dsciod_flags_t I_FLAG_VAL,
    output logic               O_ISSUE_VALID,
    output logic               O_ISSUE_NOP,
    output logic [47:0]        O_ISSUE_INSTR,
    output logic               O_ISSUE_DOUBLE,
    output dsciod_class_t      O_ISSUE_CLASS,
    output dsciod_fields_t     O_FIELDS,
    output dsciod_err_t        O_ERR,
    output dsciod_flags_t      O_FLAGS
);

    function automatic dsciod_class_t classify(input logic [7:0] opc);
        case (opc)
            `DSCIOD_OP_NOP:      classify = CLS_NOP;
            `DSCIOD_OP_COND:     classify = CLS_COND;
            `DSCIOD_OP_BRANCH:   classify = CLS_BRANCH;
            `DSCIOD_OP_COMPUTED: classify = CLS_BRANCH;
            `DSCIOD_OP_IND_JUMP: classify = CLS_IND;
            `DSCIOD_OP_IND_CALL: classify = CLS_IND;
            `DSCIOD_OP_TBL_RD:   classify = CLS_TABLE;
            `DSCIOD_OP_TBL_WR:   classify = CLS_TABLE;
            `DSCIOD_OP_RETURN:   classify = CLS_RETURN;
            `DSCIOD_OP_INT_RET:  classify = CLS_RETURN;
            `DSCIOD_OP_SKIP:     classify = CLS_SKIP;
            `DSCIOD_OP_JUMP_DBL: classify = CLS_DOUBLE;
            `DSCIOD_OP_CALL_DBL: classify = CLS_DOUBLE;
            `DSCIOD_OP_MOV_DBL:  classify = CLS_DOUBLE;
            default:             classify = CLS_PLAIN;
        endcase
    endfunction

    function automatic logic [1:0] extra_cycles(
        input dsciod_class_t cls,
        input logic          cond,
        input logic          pcw
    );
        case (cls)
            CLS_PLAIN:  extra_cycles = pcw ? `DSCIOD_CYC_TAKEN - 2'd1 : 2'd0;
            CLS_COND:   extra_cycles = cond ? `DSCIOD_CYC_TAKEN - 2'd1 : 2'd0;
            CLS_BRANCH: extra_cycles = `DSCIOD_CYC_BRANCH - 2'd1;
            CLS_IND:    extra_cycles = `DSCIOD_CYC_IND - 2'd1;
            CLS_TABLE:  extra_cycles = `DSCIOD_CYC_TABLE - 2'd1;
            CLS_RETURN: extra_cycles = `DSCIOD_CYC_RETURN - 2'd1;
            CLS_DOUBLE: extra_cycles = `DSCIOD_CYC_DOUBLE - 2'd1;
            default:    extra_cycles = 2'd0;
        endcase
    endfunction

    dsciod_state_t  state;
    dsciod_state_t  next_state;
    logic [1:0]     fill_cnt;
    logic [1:0]     next_extra;
    logic [23:0]    first_word;
    logic [47:0]    cap_word;
    logic           accept;
    logic           load;
    dsciod_class_t  in_class;
    dsciod_fields_t next_fields;
    dsciod_err_t    next_err;
    dsciod_pf_t     x_pf;
    dsciod_pf_t     y_pf;
    logic [3:0]     x_dest;
    logic [3:0]     y_dest;

    // handshake with the fetch stream
    always_comb begin
        case (state)
            S_FETCH, S_SECOND, S_SKIP, S_SKIP2: O_FETCH_READY = 1'b1;
            default:                            O_FETCH_READY = 1'b0;
        endcase
    end

    assign accept   = I_FETCH_VALID & O_FETCH_READY;
    assign in_class = classify(I_FETCH_WORD[23:16]);

    // skipped words issue as no-ops in the cycle they are taken
    always_comb begin
        case (state)
            S_EXEC:          O_ISSUE_VALID = 1'b1;
            S_FILL:          O_ISSUE_VALID = 1'b1;
            S_SKIP, S_SKIP2: O_ISSUE_VALID = accept;
            default:         O_ISSUE_VALID = 1'b0;
        endcase
    end

    assign O_ISSUE_NOP = (state != S_EXEC) | (O_ISSUE_CLASS == CLS_NOP);

    assign next_extra = extra_cycles(O_ISSUE_CLASS, I_COND_TRUE, I_PC_WRITE);

    always_comb begin
        next_state = state;
        case (state)
            S_FETCH: begin
                if (accept) begin
                    next_state = (in_class == CLS_DOUBLE) ? S_SECOND : S_EXEC;
                end
            end
            S_SECOND: begin
                if (accept) begin
                    next_state = S_EXEC;
                end
            end
            S_EXEC: begin
                if (O_ISSUE_CLASS == CLS_SKIP && I_SKIP_TAKEN) begin
                    next_state = S_SKIP;
                end else if (next_extra != 2'd0) begin
                    next_state = S_FILL;
                end else begin
                    next_state = S_FETCH;
                end
            end
            S_FILL: begin
                if (fill_cnt == 2'd1) begin
                    next_state = S_FETCH;
                end
            end
            S_SKIP: begin
                if (accept) begin
                    next_state = (in_class == CLS_DOUBLE) ? S_SKIP2 : S_FETCH;
                end
            end
            S_SKIP2: begin
                if (accept) begin
                    next_state = S_FETCH;
                end
            end
            default: next_state = S_FETCH;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state <= S_FETCH;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            fill_cnt <= 2'd0;
        end else if (state == S_EXEC) begin
            fill_cnt <= next_extra;
        end else if (state == S_FILL) begin
            fill_cnt <= fill_cnt - 2'd1;
        end
    end

    // instruction assembly
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            first_word <= 24'h000000;
        end else if (state == S_FETCH && accept) begin
            first_word <= I_FETCH_WORD;
        end
    end

    assign cap_word = (state == S_SECOND) ? {first_word, I_FETCH_WORD}
                                          : {I_FETCH_WORD, 24'h000000};
    assign load = accept & ((state == S_SECOND) | ((state == S_FETCH) & (in_class != CLS_DOUBLE)));

    dsciod_pfdec #(
        .BASE_REG (4'h8)
    ) u_xpf (
        .i_code  (cap_word[`DSCIOD_XPF_LO +: 4]),
        .i_dcode (cap_word[`DSCIOD_XD_LO +: 2]),
        .o_pf    (x_pf),
        .o_dest  (x_dest)
    );

    dsciod_pfdec #(
        .BASE_REG (4'ha)
    ) u_ypf (
        .i_code  (cap_word[`DSCIOD_YPF_LO +: 4]),
        .i_dcode (cap_word[`DSCIOD_YD_LO +: 2]),
        .o_pf    (y_pf),
        .o_dest  (y_dest)
    );

    // operand field decode
    always_comb begin
        next_fields = '0;
        next_err    = '0;
        next_fields.opcode           = cap_word[`DSCIOD_OPC_LO +: 8];
        next_fields.byte_mode        = cap_word[`DSCIOD_BYTE_BIT];
        next_fields.base_work_reg    = cap_word[`DSCIOD_BASE_LO +: 4];
        next_fields.source_work_reg  = cap_word[`DSCIOD_SRC_LO +: 4];
        next_fields.dest_work_reg    = cap_word[`DSCIOD_DEST_LO +: 4];
        next_fields.default_work_reg = `DSCIOD_DEFAULT_REG;
        next_fields.bit_select_field = cap_word[`DSCIOD_BITSEL_LO +: 4];
        next_fields.acc_sel          = cap_word[`DSCIOD_ACC_BIT];
        next_fields.unsigned_literal_ten = cap_word[`DSCIOD_ULIT_LO +: 10];
        if (next_fields.byte_mode) begin
            next_fields.unsigned_literal_ten[9:8] = 2'h0;
            next_err.lit_range = |cap_word[`DSCIOD_ULIT_LO + 8 +: 2];
        end
        next_fields.signed_literal_ten = {{6{cap_word[`DSCIOD_ULIT_LO + 9]}},
                                          cap_word[`DSCIOD_ULIT_LO +: 10]};
        next_fields.program_addr_literal = {cap_word[`DSCIOD_ADDR_HI_LO +: 7],
                                            cap_word[`DSCIOD_ADDR_LO_LO + 1 +: 15],
                                            1'b0};
        next_err.addr_odd = cap_word[`DSCIOD_ADDR_LO_LO];
        next_fields.acc_writeback_dest = cap_word[`DSCIOD_WB_LO +: 2];
        if (next_fields.acc_writeback_dest == `DSCIOD_WB_BAD) begin
            next_fields.acc_writeback_dest = 2'h0;
            next_err.wb_code = 1'b1;
        end
        if (next_fields.opcode == `DSCIOD_OP_SQR) begin
            next_fields.mul_m = {2'h1, cap_word[`DSCIOD_MUL_LO +: 2]};
            next_fields.mul_n = {2'h1, cap_word[`DSCIOD_MUL_LO +: 2]};
        end else if (next_fields.opcode == `DSCIOD_OP_MPY) begin
            case (cap_word[`DSCIOD_MUL_LO +: 3])
                3'h0: {next_fields.mul_m, next_fields.mul_n} = {4'h4, 4'h5};
                3'h1: {next_fields.mul_m, next_fields.mul_n} = {4'h4, 4'h6};
                3'h2: {next_fields.mul_m, next_fields.mul_n} = {4'h4, 4'h7};
                3'h3: {next_fields.mul_m, next_fields.mul_n} = {4'h5, 4'h6};
                3'h4: {next_fields.mul_m, next_fields.mul_n} = {4'h5, 4'h7};
                3'h5: {next_fields.mul_m, next_fields.mul_n} = {4'h6, 4'h7};
                default: begin
                    {next_fields.mul_m, next_fields.mul_n} = {4'h4, 4'h5};
                    next_err.mul_pair = 1'b1;
                end
            endcase
        end
        next_fields.x_prefetch_addr = x_pf;
        next_fields.y_prefetch_addr = y_pf;
        next_fields.x_prefetch_dest = x_dest;
        next_fields.y_prefetch_dest = y_dest;
        if (state == S_SECOND) begin
            next_err.second_word = |I_FETCH_WORD[23 -: `DSCIOD_ZERO_HI_W];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_ISSUE_INSTR  <= 48'h000000000000;
            O_ISSUE_DOUBLE <= 1'b0;
            O_ISSUE_CLASS  <= CLS_NOP;
            O_FIELDS       <= '0;
            O_ERR          <= '0;
        end else if (load) begin
            O_ISSUE_INSTR  <= cap_word;
            O_ISSUE_DOUBLE <= (state == S_SECOND);
            O_ISSUE_CLASS  <= classify(cap_word[`DSCIOD_OPC_LO +: 8]);
            O_FIELDS       <= next_fields;
            O_ERR          <= next_err;
        end
    end

    dsciod_flags u_flags (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (I_FLAG_WE),
        .i_val   (I_FLAG_VAL),
        .o_flags (O_FLAGS)
    );

endmodule

`default_nettype wire

// >>> dsciod_issue_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsciod_regs.svh"

module dsciod_monitor
    import dsciod_pkg::*;
(
    input wire logic           I_CLK,
    input wire logic           I_RST_N,
    input wire logic           I_FETCH_VALID,
    input wire logic           I_COND_TRUE,
    input wire logic           I_PC_WRITE,
    input wire logic           I_SKIP_TAKEN,
    input wire dsciod_flags_t  I_FLAG_WE,
    input wire dsciod_flags_t  I_FLAG_VAL,
    input wire logic           O_FETCH_READY,
    input wire logic           O_ISSUE_VALID,
    input wire logic           O_ISSUE_NOP,
    input wire logic           O_ISSUE_DOUBLE,
    input wire logic [47:0]    O_ISSUE_INSTR,
    input wire dsciod_class_t  O_ISSUE_CLASS,
    input wire dsciod_fields_t O_FIELDS,
    input wire dsciod_err_t    O_ERR,
    input wire dsciod_flags_t  O_FLAGS
);
    logic       ex;
    logic [8:0] nf;
    assign ex = O_ISSUE_VALID && !O_ISSUE_NOP;
    assign nf = (I_FLAG_VAL & I_FLAG_WE) | (O_FLAGS & ~I_FLAG_WE);

    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    AST_PLAIN_ONE: assert property (ex && O_ISSUE_CLASS == CLS_PLAIN && !I_PC_WRITE
        |=> O_FETCH_READY) else $error("plain instruction took extra cycles");
    AST_TAKEN_TWO: assert property (ex && ((O_ISSUE_CLASS == CLS_PLAIN && I_PC_WRITE)
        || (O_ISSUE_CLASS == CLS_COND && I_COND_TRUE))
        |=> O_ISSUE_VALID && O_ISSUE_NOP && !O_FETCH_READY ##1 O_FETCH_READY)
        else $error("taken instruction not two cycles");
    AST_FLOW_TWO: assert property (ex && O_ISSUE_CLASS inside {CLS_BRANCH, CLS_IND, CLS_TABLE}
        |=> O_ISSUE_VALID && O_ISSUE_NOP ##1 O_FETCH_READY) else $error("flow op not two cycles");
    AST_RET_THREE: assert property (ex && O_ISSUE_CLASS == CLS_RETURN
        |=> (O_ISSUE_VALID && O_ISSUE_NOP)[*2] ##1 O_FETCH_READY) else $error("return not three");
    AST_DBL_TWO: assert property (ex && O_ISSUE_DOUBLE
        |=> O_ISSUE_VALID && O_ISSUE_NOP ##1 O_FETCH_READY) else $error("double not two cycles");
    AST_SKIP_NOP: assert property (ex && O_ISSUE_CLASS == CLS_SKIP && I_SKIP_TAKEN
        |=> O_FETCH_READY && O_ISSUE_VALID == I_FETCH_VALID && (!I_FETCH_VALID || O_ISSUE_NOP))
        else $error("skipped word not issued as no-op");
    AST_SECOND_ERR: assert property (ex && O_ISSUE_DOUBLE
        |-> O_ERR.second_word == (O_ISSUE_INSTR[23:16] != 8'h00)) else $error("second word flag");
    AST_WB_LEGAL: assert property (ex |-> O_FIELDS.acc_writeback_dest != `DSCIOD_WB_BAD)
        else $error("write-back code illegal");
    AST_LIT_BYTE: assert property (ex && O_FIELDS.byte_mode
        |-> O_FIELDS.unsigned_literal_ten[9:8] == 2'b00) else $error("byte literal above 255");
    AST_ADDR_EVEN: assert property (ex |-> !O_FIELDS.program_addr_literal[0])
        else $error("program address odd");
    AST_SLIT_EXT: assert property (ex
        |-> O_FIELDS.signed_literal_ten[15:10] == {6{O_FIELDS.signed_literal_ten[9]}})
        else $error("signed literal not extended");
    AST_SQR_PAIR: assert property (ex && O_ISSUE_INSTR[47:40] == `DSCIOD_OP_SQR
        |-> O_FIELDS.mul_m == O_FIELDS.mul_n && O_FIELDS.mul_m[3:2] == 2'b01)
        else $error("square pair illegal");
    AST_MPY_PAIR: assert property (ex && O_ISSUE_INSTR[47:40] == `DSCIOD_OP_MPY
        |-> O_FIELDS.mul_m[3:2] == 2'b01 && O_FIELDS.mul_n[3:2] == 2'b01
        && O_FIELDS.mul_m < O_FIELDS.mul_n) else $error("multiply pair illegal");
    AST_PF_DEST: assert property (ex |-> O_FIELDS.x_prefetch_dest[3:2] == 2'b01
        && O_FIELDS.y_prefetch_dest[3:2] == 2'b01) else $error("prefetch destination illegal");
    AST_IMPLIED_ZERO: assert property (ex |-> O_FIELDS.default_work_reg == 4'h0)
        else $error("implied register not zero");
    AST_FLAG_UPD: assert property (1'b1 |=> O_FLAGS == $past(nf))
        else $error("status flags wrong");
endmodule

bind dsciod_issue dsciod_monitor mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_FETCH_VALID(I_FETCH_VALID), .I_COND_TRUE(I_COND_TRUE), .I_PC_WRITE(I_PC_WRITE),
    .I_SKIP_TAKEN(I_SKIP_TAKEN), .I_FLAG_WE(I_FLAG_WE), .I_FLAG_VAL(I_FLAG_VAL),
    .O_FETCH_READY(O_FETCH_READY), .O_ISSUE_VALID(O_ISSUE_VALID), .O_ISSUE_NOP(O_ISSUE_NOP),
    .O_ISSUE_DOUBLE(O_ISSUE_DOUBLE), .O_ISSUE_INSTR(O_ISSUE_INSTR),
    .O_ISSUE_CLASS(O_ISSUE_CLASS), .O_FIELDS(O_FIELDS), .O_ERR(O_ERR), .O_FLAGS(O_FLAGS));
`default_nettype wire

// >>> dsciod_pmem.sv
`timescale 1ns/1ps
`default_nettype none

module dsciod_pmem (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    input  wire logic   i_ready,
    input  wire logic   i_slow,
    output logic        o_valid,
    output logic [23:0] o_word
);
    logic [23:0] q[$];
    integer      seed = 32'h1c3d;
    initial begin
        o_valid = 1'b0;
        o_word  = 24'h0;
    end
    // word held until taken; idle word flips every cycle
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
        end else if (!o_valid || i_ready) begin
            if (o_valid)
                void'(q.pop_front());
            if (q.size() > 0 && !(i_slow && ($random(seed) & 3) != 0)) begin
                o_valid <= 1'b1;
                o_word  <= q[0];
            end else begin
                o_valid <= 1'b0;
                o_word  <= ~o_word;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb_dsciod_issue.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsciod_regs.svh"

module tb_dsciod_issue;
    import dsciod_pkg::*;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic           cond = 1'b0;
    logic           pcw = 1'b0;
    logic           skip = 1'b0;
    logic           slow = 1'b0;
    dsciod_flags_t  we = '0;
    dsciod_flags_t  val = '0;
    logic           f_valid, f_ready, v, nop, dbl;
    logic [23:0]    f_word;
    logic [47:0]    instr;
    dsciod_class_t  cls;
    dsciod_fields_t fld;
    dsciod_err_t    err;
    dsciod_flags_t  flg;
    logic [31:0]    rv;
    logic [48:0]    e;
    logic [48:0]    exp_q[$];
    integer         seed = 32'hb4a9;
    int             mismatches = 0;
    int             n_tests = 0;
    int             run = 0;
    int             need = 0;
    logic [7:0]     ops[15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                8'h31, 8'h37, 8'ha4, 8'hba, 8'hbb, 8'hc0, 8'hf0};
    logic [7:0]     mtab[8] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67, 8'h45, 8'h45};
    logic [3:0]     stp[7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'hc, 4'he};

    always #2.5 clk = ~clk;

    dsciod_issue dut (.I_CLK(clk), .I_RST_N(rst_n), .I_FETCH_VALID(f_valid),
        .I_FETCH_WORD(f_word), .O_FETCH_READY(f_ready), .I_COND_TRUE(cond),
        .I_PC_WRITE(pcw), .I_SKIP_TAKEN(skip), .I_FLAG_WE(we), .I_FLAG_VAL(val),
        .O_ISSUE_VALID(v), .O_ISSUE_NOP(nop), .O_ISSUE_INSTR(instr), .O_ISSUE_DOUBLE(dbl),
        .O_ISSUE_CLASS(cls), .O_FIELDS(fld), .O_ERR(err), .O_FLAGS(flg));
    dsciod_pmem pm (.i_clk(clk), .i_rst_n(rst_n), .i_ready(f_ready), .i_slow(slow),
        .o_valid(f_valid), .o_word(f_word));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic int cyc(input logic [7:0] op, input logic c, input logic p);
        case (op)
            `DSCIOD_OP_COND: return c ? 2 : 1;
            `DSCIOD_OP_RETURN, `DSCIOD_OP_INT_RET: return 3;
            `DSCIOD_OP_BRANCH, `DSCIOD_OP_COMPUTED, `DSCIOD_OP_IND_JUMP, `DSCIOD_OP_IND_CALL,
            `DSCIOD_OP_TBL_RD, `DSCIOD_OP_TBL_WR, `DSCIOD_OP_JUMP_DBL, `DSCIOD_OP_CALL_DBL,
            `DSCIOD_OP_MOV_DBL: return 2;
            `DSCIOD_OP_SKIP: return 1;
            default: return p ? 2 : 1;
        endcase
    endfunction

    task automatic push(input logic [23:0] w1, input logic [23:0] w2);
        logic d;
        d = w1[23:16] inside {`DSCIOD_OP_JUMP_DBL, `DSCIOD_OP_CALL_DBL, `DSCIOD_OP_MOV_DBL};
        pm.q.push_back(w1);
        if (d)
            pm.q.push_back(w2);
        exp_q.push_back({d, w1, d ? w2 : 24'h0});
    endtask

    // random condition, skip and flag stimulus
    always @(posedge clk) begin
        rv = $random(seed);
        cond <= rv[0];
        pcw  <= rv[1];
        skip <= rv[2];
        we   <= rv[12:4];
        val  <= rv[21:13];
    end

    // operand and cycle scoreboard, sampled mid-cycle
    always @(negedge clk) begin
        if (rst_n && v && !nop && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(instr, e[47:0]);
            chk(dbl, e[48]);
            chk(err.second_word, e[48] && e[23:16] != 8'h00);
            chk({fld.base_work_reg, fld.dest_work_reg}, {e[37:34], e[33:30]});
            chk(fld.source_work_reg, e[27:24]);
            chk(fld.bit_select_field, e[27:24]);
            chk(fld.program_addr_literal, {e[6:0], e[39:25], 1'b0});
            chk(err.addr_odd, e[24]);
            chk(fld.signed_literal_ten, {{6{e[37]}}, e[37:28]});
            chk(fld.unsigned_literal_ten, e[38] ? {2'b00, e[35:28]} : e[37:28]);
            chk(err.lit_range, e[38] && e[37:36] != 2'b00);
            chk(fld.acc_writeback_dest, e[25:24] == 2'h3 ? 2'h0 : e[25:24]);
            chk(err.wb_code, e[25:24] == 2'h3);
            chk(fld.acc_sel, e[39]);
            if (e[47:40] == `DSCIOD_OP_MPY)
                chk({fld.mul_m, fld.mul_n}, mtab[e[38:36]]);
            chk(err.mul_pair, e[47:40] == `DSCIOD_OP_MPY && e[38:37] == 2'b11);
            chk({fld.x_prefetch_addr.none, fld.x_prefetch_addr.indexed},
                {e[29:26] == 4'h7, e[29:26] == 4'hf});
            chk({fld.y_prefetch_addr.none, fld.y_prefetch_addr.indexed},
                {e[33:30] == 4'h7, e[33:30] == 4'hf});
            if (e[28:26] != 3'h7)
                chk({fld.x_prefetch_addr.areg, fld.x_prefetch_addr.step},
                    {3'h4, e[29], stp[e[28:26]]});
            need = cyc(e[47:40], cond, pcw);
            if (e[47:40] == `DSCIOD_OP_SKIP && skip && exp_q.size() > 0)
                void'(exp_q.pop_front());
            run = 1;
        end else if (run > 0) begin
            if (f_ready) begin
                chk(run, need);
                run = 0;
            end else begin
                run++;
            end
        end
    end

    initial begin
        int r;
        logic [7:0] op;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        push(24'h40ffff, 24'h0);
        push(24'hc06000, 24'h0);
        push(24'hf05000, 24'h0);
        push(24'h04ffff, 24'hff0001);
        push(24'ha40000, 24'h0);
        push(24'h080000, 24'h001234);
        for (int i = 0; i < 600; i++) begin
            r = $random(seed) & 31;
            op = r < 15 ? ops[r] : {2'b01, 6'($random(seed))};
            push({op, 16'($random(seed))},
                 {($random(seed) & 7) == 0 ? 8'h5a : 8'h00, 16'($random(seed))});
        end
        push(24'h400000, 24'h0);
        for (int k = 0; k < 20000 && exp_q.size() > 0; k++) begin
            if (k == 2000)
                slow <= 1'b1;
            @(posedge clk);
        end
        if (exp_q.size() > 0)
            mismatches++;
        repeat (4) @(posedge clk);
        finish_test();
    end

    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
